// ### hw/pll_regs_pkg.sv
// Purpose: constants and carriers for the synthesizer control register bank
// Assumes: register accesses arrive as decoded word writes and reads on i_clk_sys
// Notes: the forwarding packet is shifted out by pll_fwd_shifter
`default_nettype none
package pll_regs_pkg;
	localparam logic [4:0] ADDR_ID = 5'h00;
	localparam logic [4:0] ADDR_ENABLE = 5'h01;
	localparam logic [4:0] ADDR_REFDIV = 5'h02;
	localparam logic [4:0] ADDR_INTG = 5'h03;
	localparam logic [4:0] ADDR_FRAC = 5'h04;
	localparam logic [4:0] ADDR_WINDOW = 5'h05;
	localparam int SOFT_RESET_BIT = 5;
	localparam int SEL_PIN_BIT = 0;
	localparam int SW_ENABLE_BIT = 1;
	localparam int HOLD_LO_BIT = 2;
	localparam int HOLD_COUNT = 6;
	localparam logic [9:0] ENABLE_RESET = 10'h002;
	localparam logic [13:0] REFDIV_RESET = 14'h0001;
	localparam logic [18:0] INTG_RESET = 19'h00019;
	localparam logic [23:0] FRAC_RESET = 24'h000000;
	localparam logic [15:0] WINDOW_RESET = 16'h0000;
	localparam int FWD_BITS = 16;
	typedef struct packed {
		logic [8:0] subsystem_payload;
		logic [3:0] subsystem_reg_index;
		logic [2:0] subsystem_target_id;
	} fwd_packet_t;
	typedef struct packed {
		logic valid;
		logic write;
		logic [4:0] addr;
		logic [23:0] data;
	} reg_access_t;
endpackage
`default_nettype wire

// ### hw/pll_fwd_shifter.sv
// Purpose: shifts a forwarding packet onto the internal serial link
// Assumes: a start pulse is ignored while a shift is under way
// Notes: one bit per clock, framed by o_frame
`timescale 1ns/1ps
`default_nettype none
module pll_fwd_shifter
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_start,
	input wire logic [15:0] i_packet,
	output logic o_busy,
	output logic o_frame,
	output logic o_sdata
);
	typedef enum logic {IDLE, SHIFT} shift_state_t;
	shift_state_t state_r;
	logic [15:0] shreg_r;
	logic [4:0] cnt_r;

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_r <= IDLE;
			shreg_r <= 16'h0000;
			cnt_r <= 5'h00;
		end
		else
		begin
			case (state_r)
				IDLE:
				begin
					if (i_start)
					begin
						state_r <= SHIFT;
						shreg_r <= i_packet;
						cnt_r <= 5'(pll_regs_pkg::FWD_BITS - 1);
					end
				end
				SHIFT:
				begin
					shreg_r <= {shreg_r[14:0], 1'b0};
					cnt_r <= cnt_r - 5'h01;
					if (cnt_r == 5'h00)
					begin
						state_r <= IDLE;
					end
				end
				default: state_r <= IDLE;
			endcase
		end
	end

	assign o_busy = (state_r == SHIFT);
	assign o_frame = (state_r == SHIFT);
	assign o_sdata = (state_r == SHIFT) ? shreg_r[15] : 1'b0;

	// frame lasts exactly sixteen cycles
	a_frame_length: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		$rose(o_frame) |-> o_frame [*8] ##1 o_frame [*8] ##1 !o_frame)
		else $error("frame length wrong");
	a_first_bit_msb: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(state_r == IDLE && i_start) |=> o_sdata == $past(i_packet[15]))
		else $error("first bit not msb");
endmodule
`default_nettype wire

// ### hw/pll_control_register_bank.sv
// Purpose: control register bank of a fractional-N synthesizer
// Assumes: the serial port front end delivers whole decoded accesses as one-cycle pulses
// Notes: window writes arriving during a shift are queued for one packet
`timescale 1ns/1ps
`default_nettype none
module pll_control_register_bank
#(
	parameter logic [23:0] DEVICE_IDENTITY_WORD = 24'h123456 // arbitrary value
)
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire pll_regs_pkg::reg_access_t i_acc,
	input wire logic i_chip_enable_pin,
	input wire logic [8:0] i_cal_payload,
	input wire logic i_cal_valid,
	output logic [23:0] o_rdata,
	output logic o_rvalid,
	output logic [4:0] o_open_read_addr,
	output logic o_soft_reset,
	output logic o_synth_enable,
	output logic [5:0] o_hold_powered,
	output logic [13:0] o_ref_divider,
	output logic [18:0] o_int_word,
	output logic [23:0] o_frac_word,
	output logic o_fwd_frame,
	output logic o_fwd_sdata
);
	logic pin_s1_r;
	logic pin_s2_r;
	logic [9:0] enable_r;
	logic [13:0] refdiv_r;
	logic [18:0] intg_r;
	logic [23:0] frac_r;
	pll_regs_pkg::fwd_packet_t window_r;
	logic [4:0] rd_addr_r;
	logic soft_r;
	logic pending_r;
	logic launch;
	logic busy;
	logic wr;
	logic rd;
	logic win_wr;

	assign wr = i_acc.valid && i_acc.write;
	assign rd = i_acc.valid && !i_acc.write;
	assign win_wr = wr && i_acc.addr == pll_regs_pkg::ADDR_WINDOW;

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
		end
		else
		begin
			pin_s1_r <= i_chip_enable_pin;
			pin_s2_r <= pin_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////
	// identity never written
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rd_addr_r <= 5'h00;
			soft_r <= 1'b0;
		end
		else
		begin
			soft_r <= 1'b0;
			if (wr && i_acc.addr == pll_regs_pkg::ADDR_ID)
			begin
				rd_addr_r <= i_acc.data[4:0];
				soft_r <= i_acc.data[pll_regs_pkg::SOFT_RESET_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			enable_r <= pll_regs_pkg::ENABLE_RESET;
			refdiv_r <= pll_regs_pkg::REFDIV_RESET;
			intg_r <= pll_regs_pkg::INTG_RESET;
			frac_r <= pll_regs_pkg::FRAC_RESET;
		end
		else if (soft_r)
		begin
			enable_r <= pll_regs_pkg::ENABLE_RESET;
			refdiv_r <= pll_regs_pkg::REFDIV_RESET;
			intg_r <= pll_regs_pkg::INTG_RESET;
			frac_r <= pll_regs_pkg::FRAC_RESET;
		end
		else if (wr)
		begin
			if (i_acc.addr == pll_regs_pkg::ADDR_ENABLE)
			begin
				enable_r <= i_acc.data[9:0];
			end
			else if (i_acc.addr == pll_regs_pkg::ADDR_REFDIV)
			begin
				refdiv_r <= i_acc.data[13:0];
			end
			else if (i_acc.addr == pll_regs_pkg::ADDR_INTG)
			begin
				intg_r <= i_acc.data[18:0];
			end
			else if (i_acc.addr == pll_regs_pkg::ADDR_FRAC)
			begin
				frac_r <= i_acc.data[23:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// window holds the latest written packet, with calibration replacing only its payload; a write during a shift waits
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			window_r <= pll_regs_pkg::WINDOW_RESET;
			pending_r <= 1'b0;
		end
		else
		begin
			if (win_wr)
			begin
				window_r <= i_acc.data[15:0];
			end
			else if (i_cal_valid)
			begin
				window_r.subsystem_payload <= i_cal_payload;
			end
			if (win_wr || i_cal_valid)
			begin
				pending_r <= 1'b1;
			end
			else if (launch)
			begin
				pending_r <= 1'b0;
			end
		end
	end

	assign launch = pending_r && !busy;

	pll_fwd_shifter u_shift
	(
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_start(launch),
		.i_packet(window_r),
		.o_busy(busy),
		.o_frame(o_fwd_frame),
		.o_sdata(o_fwd_sdata)
	);

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_rdata <= 24'h000000;
			o_rvalid <= 1'b0;
		end
		else
		begin
			o_rvalid <= rd;
			if (rd)
			begin
				if (i_acc.addr == pll_regs_pkg::ADDR_ID)
				begin
					o_rdata <= DEVICE_IDENTITY_WORD;
				end
				else if (i_acc.addr == pll_regs_pkg::ADDR_ENABLE)
				begin
					o_rdata <= {14'h0000, enable_r};
				end
				else if (i_acc.addr == pll_regs_pkg::ADDR_REFDIV)
				begin
					o_rdata <= {10'h000, refdiv_r};
				end
				else if (i_acc.addr == pll_regs_pkg::ADDR_INTG)
				begin
					o_rdata <= {5'h00, intg_r};
				end
				else if (i_acc.addr == pll_regs_pkg::ADDR_FRAC)
				begin
					o_rdata <= frac_r;
				end
				else if (i_acc.addr == pll_regs_pkg::ADDR_WINDOW)
				begin
					o_rdata <= {8'h00, window_r};
				end
				else
				begin
					o_rdata <= 24'h000000;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// enable source select
	assign o_synth_enable = enable_r[pll_regs_pkg::SEL_PIN_BIT] ? pin_s2_r
		: enable_r[pll_regs_pkg::SW_ENABLE_BIT];
	assign o_hold_powered = enable_r[pll_regs_pkg::HOLD_LO_BIT +: pll_regs_pkg::HOLD_COUNT];
	assign o_open_read_addr = rd_addr_r;
	assign o_soft_reset = soft_r;
	assign o_ref_divider = refdiv_r;
	assign o_int_word = intg_r;
	assign o_frac_word = frac_r;

	////////////////////////////////////////////////////////////////////
	a_id_fixed: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		rd && i_acc.addr == pll_regs_pkg::ADDR_ID |=> o_rvalid && o_rdata == DEVICE_IDENTITY_WORD)
		else $error("identity read wrong");
	a_id_after_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		wr && i_acc.addr == pll_regs_pkg::ADDR_ID ##[1:4] rd && i_acc.addr == pll_regs_pkg::ADDR_ID
		|=> o_rdata == DEVICE_IDENTITY_WORD)
		else $error("identity altered by write");
	a_read_addr_cap: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		wr && i_acc.addr == pll_regs_pkg::ADDR_ID |=> o_open_read_addr == $past(i_acc.data[4:0]))
		else $error("read address not captured");
	a_soft_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		wr && i_acc.addr == pll_regs_pkg::ADDR_ID && i_acc.data[5] |=> o_soft_reset ##1 enable_r == 10'h002)
		else $error("soft reset missing");
	a_enable_source: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!enable_r[0] |-> o_synth_enable == enable_r[1])
		else $error("software enable not followed");
	a_pin_source: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		enable_r[0] && $stable(enable_r) |-> o_synth_enable == $past(i_chip_enable_pin, 2))
		else $error("pin enable not followed");
	a_hold_bits: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		wr && i_acc.addr == pll_regs_pkg::ADDR_ENABLE && !soft_r |=> o_hold_powered == $past(i_acc.data[7:2]))
		else $error("hold bits wrong");
	a_cal_payload_only: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_cal_valid && !win_wr |=> window_r.subsystem_payload == $past(i_cal_payload)
		&& window_r[6:0] == $past(window_r[6:0]))
		else $error("calibration touched id or index");
	a_window_launch: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		win_wr && !busy && !pending_r |=> ##1 o_fwd_frame)
		else $error("window write not forwarded");
	a_window_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		rd && i_acc.addr == pll_regs_pkg::ADDR_WINDOW |=> o_rdata == {8'h00, $past(window_r)})
		else $error("window read wrong");
endmodule
`default_nettype wire

// ### tb/host_model.sv
// Purpose: host serial-port master issuing decoded accesses
// Assumes: xfer is entered just after a rising edge
// Notes: returns read data taken on the rvalid pulse
`timescale 1ns/1ps
`default_nettype none
module host_model
(
	input wire logic i_clk_sys,
	input wire logic [23:0] i_rdata,
	input wire logic i_rvalid,
	output var pll_regs_pkg::reg_access_t o_acc
);
	initial o_acc = '0;
	task automatic xfer(input logic w, input logic [4:0] a, input logic [23:0] d,
		output logic [23:0] q);
		q = 'x;
		o_acc.write = w;
		o_acc.addr = a;
		o_acc.data = (w && a == 5'h00) ? (d & 24'h00003F) : d;
		o_acc.valid = 1'b1;
		@(posedge i_clk_sys);
		#1;
		o_acc.valid = 1'b0;
		for (int i = 0; i < 3 && !w; i++)
		begin
			if (i_rvalid === 1'b1)
			begin
				q = i_rdata;
				break;
			end
			@(posedge i_clk_sys);
			#1;
		end
		@(posedge i_clk_sys);
		#1;
	endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Purpose: self-checking bench of the control register bank
// Assumes: inputs change 1 ns after the rising edge
// Notes: forwarded packets are gathered bit by bit
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
$display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	localparam logic [23:0] ID = 24'h5A5A5A; // arbitrary value
	logic clk, rst_n, pin, cal_v, srst, en, rvalid, frame, sd;
	logic [8:0] cal_p;
	logic [4:0] ora;
	logic [5:0] hold;
	logic [13:0] rdiv;
	logic [18:0] iw;
	logic [23:0] fw, rdata, q;
	logic [15:0] s, s2;
	pll_regs_pkg::reg_access_t acc;
	int fails, checks_done, cyc, srst_cnt;
	host_model h (.i_clk_sys(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_acc(acc));
	pll_control_register_bank #(.DEVICE_IDENTITY_WORD(ID)) dut (.i_clk_sys(clk),
		.i_rst_n(rst_n), .i_acc(acc), .i_chip_enable_pin(pin), .i_cal_payload(cal_p),
		.i_cal_valid(cal_v), .o_rdata(rdata), .o_rvalid(rvalid), .o_open_read_addr(ora),
		.o_soft_reset(srst), .o_synth_enable(en), .o_hold_powered(hold),
		.o_ref_divider(rdiv), .o_int_word(iw), .o_frac_word(fw), .o_fwd_frame(frame),
		.o_fwd_sdata(sd));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(negedge clk)
	begin
		cyc++;
		if (srst === 1'b1)
			srst_cnt++;
		if (cyc == 3000)
		begin
			fails++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wr(input logic [4:0] a, input logic [23:0] d);
		h.xfer(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [23:0] e);
		h.xfer(1'b0, a, 24'h000000, q);
		`CHK(q, e)
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// gathers one framed packet, counting frame cycles
	task automatic grab(output logic [15:0] p);
		int f;
		f = 0;
		for (int i = 0; i < 6 && frame !== 1'b1; i++)
			tick(1);
		for (int k = 0; k < 16; k++)
		begin
			p = {p[14:0], sd};
			f += (frame === 1'b1);
			tick(1);
		end
		`CHK(f, 16)
	endtask
	task automatic t_reset();
		rd_chk(5'h01, 24'h000002);
		rd_chk(5'h02, 24'h000001);
		rd_chk(5'h03, 24'h000019);
		rd_chk(5'h04, 24'h000000);
		rd_chk(5'h05, 24'h000000);
		`CHK(en, 1'b1)
		$display("test reset done");
	endtask
	task automatic t_ident();
		wr(5'h00, 24'hFFFFC3);
		`CHK(ora, 5'h03)
		rd_chk(5'h00, ID);
		wr(5'h00, 24'h00001F);
		`CHK(ora, 5'h1F)
		rd_chk(5'h00, ID);
		$display("test identity done");
	endtask
	task automatic t_enable();
		wr(5'h01, 24'h0000FD);
		tick(3);
		`CHK(en, 1'b0)
		`CHK(hold, 6'h3F)
		pin = 1'b1;
		tick(3);
		`CHK(en, 1'b1)
		wr(5'h01, 24'h0000A0);
		`CHK(en, 1'b0)
		`CHK(hold, 6'h28)
		wr(5'h01, 24'h000302);
		rd_chk(5'h01, 24'h000302);
		`CHK(en, 1'b1)
		$display("test enable done");
	endtask
	task automatic t_regs();
		wr(5'h02, 24'h003FFF);
		wr(5'h03, 24'h07FFFC);
		wr(5'h04, 24'hFFFFFF);
		rd_chk(5'h02, 24'h003FFF);
		rd_chk(5'h03, 24'h07FFFC);
		`CHK(rdiv, 14'h3FFF)
		`CHK(fw, 24'hFFFFFF)
		wr(5'h03, 24'h000010);
		`CHK(iw, 19'h00010)
		wr(5'h00, 24'h000020);
		tick(2);
		`CHK(srst_cnt, 1)
		`CHK(rdiv, 14'h0001)
		`CHK(iw, 19'h00019)
		rd_chk(5'h04, 24'h000000);
		rd_chk(5'h01, 24'h000002);
		$display("test registers done");
	endtask
	task automatic t_window();
		wr(5'h05, 24'h00FF10);
		grab(s);
		`CHK(s, 16'hFF10)
		`CHK(frame, 1'b0)
		rd_chk(5'h05, 24'h00FF10);
		wr(5'h05, 24'h000380);
		fork
			grab(s);
			begin
				tick(4);
				wr(5'h05, 24'h008000);
			end
		join
		grab(s2);
		`CHK(s, 16'h0380)
		`CHK(s2, 16'h8000)
		cal_p = 9'h155;
		cal_v = 1'b1;
		tick(1);
		cal_v = 1'b0;
		grab(s);
		`CHK(s, 16'hAA80)
		rd_chk(5'h05, 24'h00AA80);
		$display("test window done");
	endtask
	initial
	begin
		rst_n = 1'b0;
		pin = 1'b0;
		cal_v = 1'b0;
		cal_p = 9'h000;
		tick(3);
		rst_n = 1'b1;
		t_reset();
		t_ident();
		t_enable();
		t_regs();
		t_window();
		conclude();
	end
endmodule
`default_nettype wire
